// ==== hdl/branch_pkg.sv ====
// branch_pkg: constants, encodings and helpers for the conditional branch unit
// assumes: single core clock, 13-bit program counter, 24-bit accumulators
package branch_pkg;

	// ---------------------------------------------------------------
	// widths
	// ---------------------------------------------------------------
	localparam int unsigned PC_W     = 13;          // 8 kB program space
	localparam int unsigned ACC_W    = 24;
	localparam int unsigned BIT_SEL_W = 5;
	localparam int unsigned LEN_W    = 2;
	localparam int unsigned CNT_W    = 3;

	typedef logic [PC_W-1:0]  pc_t;
	typedef logic [ACC_W-1:0] acc_t;
	typedef logic [7:0]       byte_t;

	// highest selectable accumulator bit
	localparam logic [BIT_SEL_W-1:0] BIT_INDEX_MAX = 5'h17;

	// ---------------------------------------------------------------
	// opcode encodings
	// ---------------------------------------------------------------
	// bit-test jumps: upper six bits pick the kind, low two bits pick the accumulator
	localparam logic [5:0] OP_BIT_ZERO_HI = 6'h10;  // opcode 8'h40..8'h43
	localparam logic [5:0] OP_BIT_ONE_HI  = 6'h11;  // opcode 8'h44..8'h47
	localparam byte_t      OP_NO_CARRY_REL = 8'h50;
	localparam byte_t      OP_NO_CARRY_ABS = 8'h51;

	// accumulator_operand select
	localparam logic [1:0] ACC_SEL_X = 2'h0;
	localparam logic [1:0] ACC_SEL_Y = 2'h1;
	localparam logic [1:0] ACC_SEL_Z = 2'h2;
	localparam logic [1:0] ACC_SEL_R = 2'h3;

	// ---------------------------------------------------------------
	// instruction lengths and execution cycles
	// ---------------------------------------------------------------
	localparam logic [LEN_W-1:0] LEN_BIT_JUMP = 2'h3;
	localparam logic [LEN_W-1:0] LEN_REL_JUMP = 2'h2;
	localparam logic [LEN_W-1:0] LEN_ABS_JUMP = 2'h3;
	localparam logic [LEN_W-1:0] LEN_UNKNOWN  = 2'h1;
	localparam logic [CNT_W-1:0] CYC_BIT_JUMP = 3'h4;
	localparam logic [CNT_W-1:0] CYC_REL_JUMP = 3'h3;
	localparam logic [CNT_W-1:0] CYC_ABS_JUMP = 3'h4;
	localparam logic [CNT_W-1:0] CYC_UNKNOWN  = 3'h2;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam pc_t        PC_RESET  = 13'h0000;
	localparam logic [CNT_W-1:0] CNT_RESET = 3'h0;

	typedef enum logic [0:0]
	{
		ST_IDLE = 1'b0,
		ST_EXEC = 1'b1
	} exec_state_e;

	// address of the following instruction, wraps inside 8 kB
	function automatic pc_t next_pc(input pc_t pc, input logic [LEN_W-1:0] len);
		next_pc = pc + pc_t'(len);
	endfunction

	// relative target: signed byte displacement from the following instruction
	function automatic pc_t rel_target(input pc_t pc, input logic [LEN_W-1:0] len,
		input byte_t disp);
		rel_target = next_pc(pc, len) + pc_t'({{(PC_W-8){disp[7]}}, disp});
	endfunction

endpackage

// ==== hdl/branch_eval_if.sv ====
// branch_eval_if: carries one fetched instruction to the evaluator and its verdict back
// assumes: driven by conditional_branch_unit, evaluated by branch_condition
`timescale 1ns/1ps
interface branch_eval_if;
	import branch_pkg::*;

	byte_t                opcode;
	byte_t                operand_1;
	byte_t                operand_2;
	pc_t                  instr_pc;
	acc_t                 acc_x;
	acc_t                 acc_y;
	acc_t                 acc_z;
	acc_t                 acc_r;
	logic                 carry;
	logic                 known;
	logic                 taken;
	pc_t                  target;
	logic [LEN_W-1:0]     length;
	logic [CNT_W-1:0]     cycles;

	modport ctrl (output opcode, operand_1, operand_2, instr_pc, acc_x, acc_y, acc_z, acc_r,
		carry, input known, taken, target, length, cycles);
	modport eval (input opcode, operand_1, operand_2, instr_pc, acc_x, acc_y, acc_z, acc_r,
		carry, output known, taken, target, length, cycles);
endinterface

// ==== hdl/branch_condition.sv ====
// branch_condition: combinational decode of the three conditional jumps
// assumes: operands stable for the cycle in which the controller samples the verdict
`timescale 1ns/1ps
module branch_condition
(
	branch_eval_if.eval ev
);
	import branch_pkg::*;

	acc_t                 acc_sel;
	logic [BIT_SEL_W-1:0] bit_idx;
	logic                 bit_val;

	// accumulator and bit selection; an index above 23 reads as zero
	always_comb
	begin
		case (ev.opcode[1:0])
			ACC_SEL_X: acc_sel = ev.acc_x;
			ACC_SEL_Y: acc_sel = ev.acc_y;
			ACC_SEL_Z: acc_sel = ev.acc_z;
			ACC_SEL_R: acc_sel = ev.acc_r;
			default:   acc_sel = ev.acc_x;
		endcase
		bit_idx = ev.operand_1[BIT_SEL_W-1:0];
		bit_val = (bit_idx <= BIT_INDEX_MAX) ? acc_sel[bit_idx] : 1'b0;
	end

	// verdict, length and cycle count per opcode
	always_comb
	begin
		ev.known  = 1'b1;
		ev.taken  = 1'b0;
		ev.target = next_pc(ev.instr_pc, LEN_UNKNOWN);
		ev.length = LEN_UNKNOWN;
		ev.cycles = CYC_UNKNOWN;
		if (ev.opcode[7:2] == OP_BIT_ZERO_HI)
		begin
			ev.taken  = ~bit_val;
			ev.target = rel_target(ev.instr_pc, LEN_BIT_JUMP, ev.operand_2);
			ev.length = LEN_BIT_JUMP;
			ev.cycles = CYC_BIT_JUMP;
		end
		else if (ev.opcode[7:2] == OP_BIT_ONE_HI)
		begin
			ev.taken  = bit_val;
			ev.target = rel_target(ev.instr_pc, LEN_BIT_JUMP, ev.operand_2);
			ev.length = LEN_BIT_JUMP;
			ev.cycles = CYC_BIT_JUMP;
		end
		else if (ev.opcode == OP_NO_CARRY_REL)
		begin
			ev.taken  = ~ev.carry;
			ev.target = rel_target(ev.instr_pc, LEN_REL_JUMP, ev.operand_1);
			ev.length = LEN_REL_JUMP;
			ev.cycles = CYC_REL_JUMP;
		end
		else if (ev.opcode == OP_NO_CARRY_ABS)
		begin
			ev.taken  = ~ev.carry;
			ev.target = {ev.operand_1[PC_W-9:0], ev.operand_2};
			ev.length = LEN_ABS_JUMP;
			ev.cycles = CYC_ABS_JUMP;
		end
		else
		begin
			ev.known = 1'b0;
		end
	end

endmodule // branch_condition

// ==== hdl/conditional_branch_unit.sv ====
// conditional_branch_unit: sequences the bit-test and carry-clear jumps of the core
// assumes: fetch presents opcode and both operand bytes together with instr_valid,
// accumulators and carry come from core logic on the same clock
`timescale 1ns/1ps

module conditional_branch_unit
(
	input  wire logic             core_clk,
	input  wire logic             rst_b,
	input  wire logic             instr_valid,
	input  wire branch_pkg::byte_t opcode,
	input  wire branch_pkg::byte_t operand_1,
	input  wire branch_pkg::byte_t operand_2,
	input  wire branch_pkg::pc_t  instr_pc,
	input  wire branch_pkg::acc_t acc_x,
	input  wire branch_pkg::acc_t acc_y,
	input  wire branch_pkg::acc_t acc_z,
	input  wire branch_pkg::acc_t acc_r,
	input  wire logic             carry,
	output logic                  instr_ready,
	output logic                  done,
	output logic                  branch_taken,
	output logic                  unknown_opcode,
	output branch_pkg::pc_t       pc_next
);
	import branch_pkg::*;

	// ---------------------------------------------------------------
	// evaluator hookup
	// ---------------------------------------------------------------
	branch_eval_if ev ();

	// inputs are already in the core clock domain, no synchroniser needed
	assign ev.opcode    = opcode;
	assign ev.operand_1 = operand_1;
	assign ev.operand_2 = operand_2;
	assign ev.instr_pc  = instr_pc;
	assign ev.acc_x     = acc_x;
	assign ev.acc_y     = acc_y;
	assign ev.acc_z     = acc_z;
	assign ev.acc_r     = acc_r;
	assign ev.carry     = carry;

	branch_condition u_cond
	(
		.ev (ev.eval)
	);

	// ---------------------------------------------------------------
	// sequencing state
	// ---------------------------------------------------------------
	exec_state_e          state_q;
	logic [CNT_W-1:0]     cnt_q;
	logic                 taken_q;
	logic                 known_q;
	pc_t                  dest_q;
	logic                 ready_q;
	logic                 done_q;
	logic                 taken_out_q;
	logic                 unknown_q;
	pc_t                  pc_q;
	logic                 accept;
	logic                 finish;

	assign accept = instr_valid & ready_q;
	assign finish = (state_q == ST_EXEC) && (cnt_q == CNT_W'(1));

	// state: idle until an instruction is taken, busy until its last cycle;
	// accept only happens while idle because ready is low when busy
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			state_q <= ST_IDLE;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
				begin
					if (accept)
					begin
						state_q <= ST_EXEC;
					end
				end
				ST_EXEC:
				begin
					if (finish)
					begin
						state_q <= ST_IDLE;
					end
				end
				default:
				begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// cycle counter; loaded with cycles-1 so the answer lands exactly
	// cycles-1 edges after the accepting edge, whatever the instruction form
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			cnt_q <= CNT_RESET;
		end
		else if (accept)
		begin
			cnt_q <= ev.cycles - CNT_W'(1);
		end
		else if (finish)
		begin
			cnt_q <= CNT_RESET;
		end
		else if (state_q == ST_EXEC)
		begin
			cnt_q <= cnt_q - CNT_W'(1);
		end
	end

	// verdict captured at accept so operand changes mid-instruction are harmless
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			taken_q <= 1'b0;
			known_q <= 1'b0;
			dest_q  <= PC_RESET;
		end
		else if (accept)
		begin
			taken_q <= ev.taken & ev.known;
			known_q <= ev.known;
			dest_q  <= (ev.taken & ev.known) ? ev.target
				: next_pc(instr_pc, ev.length);
		end
	end

	// ready drops on accept and returns with the answer
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			ready_q <= 1'b0;
		end
		else if (accept)
		begin
			ready_q <= 1'b0;
		end
		else if (finish || state_q == ST_IDLE)
		begin
			ready_q <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// answer outputs
	// ---------------------------------------------------------------
	// no flag output exists: these jumps never write status, so the
	// core's flags simply keep their value across a branch

	// done is a one-cycle pulse; fetch treats it as the end of the instruction
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			done_q <= 1'b0;
		end
		else
		begin
			done_q <= finish;
		end
	end

	// taken pulses with done only, so a stale verdict never steers fetch
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			taken_out_q <= 1'b0;
		end
		else if (finish)
		begin
			taken_out_q <= taken_q;
		end
		else
		begin
			taken_out_q <= 1'b0;
		end
	end

	// unknown opcode flag; the core may trap on it, the pc still moves on by one
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			unknown_q <= 1'b0;
		end
		else if (finish)
		begin
			unknown_q <= ~known_q;
		end
		else
		begin
			unknown_q <= 1'b0;
		end
	end

	// pc_next holds between answers so fetch may read it a cycle late
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			pc_q <= PC_RESET;
		end
		else if (finish)
		begin
			// 13-bit pc wraps inside 8 kB
			pc_q <= dest_q;
		end
	end

	assign instr_ready    = ready_q;
	assign done           = done_q;
	assign branch_taken   = taken_out_q;
	assign unknown_opcode = unknown_q;
	assign pc_next        = pc_q;

endmodule // conditional_branch_unit

// ==== verification/branch_unit_sva.sv ====
// branch_unit_sva: timing and target checks on the branch unit's ports
// assumes: bound to conditional_branch_unit, one clock, reset low
`timescale 1ns/1ps
module branch_unit_sva
	import branch_pkg::*;
(
	input wire logic              core_clk,
	input wire logic              rst_b,
	input wire logic              instr_valid,
	input wire branch_pkg::byte_t opcode,
	input wire branch_pkg::byte_t operand_1,
	input wire branch_pkg::byte_t operand_2,
	input wire branch_pkg::pc_t   instr_pc,
	input wire branch_pkg::acc_t  acc_x,
	input wire branch_pkg::acc_t  acc_y,
	input wire branch_pkg::acc_t  acc_z,
	input wire branch_pkg::acc_t  acc_r,
	input wire logic              carry,
	input wire logic              instr_ready,
	input wire logic              done,
	input wire logic              branch_taken,
	input wire logic              unknown_opcode,
	input wire branch_pkg::pc_t   pc_next
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	logic go;
	logic is_bit;
	logic want_t;
	acc_t acc_s;
	pc_t  bit_pc;
	pc_t  rel_pc;
	pc_t  abs_pc;
	// expected outcome worked out at the accept edge; index above 23 reads 0
	always_comb
	begin
		go = instr_valid && instr_ready;
		is_bit = opcode[7:3] == OP_BIT_ZERO_HI[5:1];
		acc_s = opcode[1] ? (opcode[0] ? acc_r : acc_z) : (opcode[0] ? acc_y : acc_x);
		want_t = (operand_1[4:0] > BIT_INDEX_MAX) ? !opcode[2] : !(acc_s[operand_1[4:0]] ^ opcode[2]);
		bit_pc = want_t ? pc_t'(instr_pc + 13'h3 + {{5{operand_2[7]}}, operand_2})
			: pc_t'(instr_pc + 13'h3);
		rel_pc = carry ? pc_t'(instr_pc + 13'h2)
			: pc_t'(instr_pc + 13'h2 + {{5{operand_1[7]}}, operand_1});
		abs_pc = carry ? pc_t'(instr_pc + 13'h3) : {operand_1[4:0], operand_2};
	end
	// the registered answer is seen N edges after the accepting edge
	a_bit_latency: assert property (go && is_bit |=> !done [*3] ##1 done)
		else $error("bit jump latency wrong");
	a_bit_taken: assert property (go && is_bit |->
		##4 branch_taken == $past(want_t, 4))
		else $error("bit jump decision wrong");
	a_bit_target: assert property (go && is_bit |->
		##4 pc_next == $past(bit_pc, 4))
		else $error("bit jump next pc wrong");
	a_rel_latency: assert property (go && opcode == OP_NO_CARRY_REL |=>
		!done [*2] ##1 done)
		else $error("relative carry jump latency wrong");
	a_abs_latency: assert property (go && opcode == OP_NO_CARRY_ABS |=>
		!done [*3] ##1 done)
		else $error("absolute carry jump latency wrong");
	a_carry_taken: assert property (go && opcode == OP_NO_CARRY_REL |->
		##3 branch_taken == !$past(carry, 3))
		else $error("carry jump decision wrong");
	a_abs_taken: assert property (go && opcode == OP_NO_CARRY_ABS |->
		##4 branch_taken == !$past(carry, 4))
		else $error("absolute carry jump decision wrong");
	a_rel_target: assert property (go && opcode == OP_NO_CARRY_REL |->
		##3 pc_next == $past(rel_pc, 3))
		else $error("relative carry jump pc wrong");
	a_abs_target: assert property (go && opcode == OP_NO_CARRY_ABS |->
		##4 pc_next == $past(abs_pc, 4))
		else $error("absolute carry jump pc wrong");
	a_unk_latency: assert property (go && !is_bit && opcode != OP_NO_CARRY_REL &&
		opcode != OP_NO_CARRY_ABS |=> !done ##1 done)
		else $error("unknown opcode latency wrong");
	a_done_pulse: assert property (done |=> !done)
		else $error("done longer than one cycle");
	a_ready_drop: assert property (go |=> !instr_ready)
		else $error("ready stayed high after accept");
	a_ready_done: assert property (done |-> instr_ready)
		else $error("ready low while answer shown");
	c_bit_taken: cover property (go && is_bit ##4 branch_taken);
	c_rel_taken: cover property (go && opcode == OP_NO_CARRY_REL ##3 branch_taken);
	c_abs_fall: cover property (go && opcode == OP_NO_CARRY_ABS ##4 !branch_taken);
endmodule // branch_unit_sva

// ==== verification/fetch_model.sv ====
// fetch_model: fetch side, offers one whole instruction and holds it until taken
// assumes: inputs changed at the falling edge, ready is registered
`timescale 1ns/1ps
module fetch_model
(
	input  wire logic         core_clk,
	input  wire logic         instr_ready,
	output logic              instr_valid,
	output branch_pkg::byte_t opcode,
	output branch_pkg::byte_t operand_1,
	output branch_pkg::byte_t operand_2,
	output branch_pkg::pc_t   instr_pc
);
	import branch_pkg::*;
	initial
	begin
		instr_valid = 1'b0;
		{opcode, operand_1, operand_2, instr_pc} = '0;
	end
	// hold the offer until an edge sees ready; released lines show inverted data
	task automatic issue(input byte_t op, input byte_t o1, input byte_t o2, input pc_t pc);
		@(negedge core_clk);
		instr_valid = 1'b1;
		{opcode, operand_1, operand_2, instr_pc} = {op, o1, o2, pc};
		while (instr_ready !== 1'b1)
			@(negedge core_clk);
		@(posedge core_clk);
		@(negedge core_clk);
		instr_valid = 1'b0;
		{opcode, operand_1, operand_2, instr_pc} = ~{op, o1, o2, pc};
	endtask
endmodule // fetch_model

// ==== verification/tb_conditional_branch_unit.sv ====
// tb_conditional_branch_unit: directed checks of the three conditional jumps
// assumes: fetch_model offers instructions, bench drives accumulators and carry
`timescale 1ns/1ps
module tb_conditional_branch_unit;
	import branch_pkg::*;
	logic  core_clk;
	logic  rst_b;
	logic  instr_valid;
	byte_t opcode;
	byte_t operand_1;
	byte_t operand_2;
	pc_t   instr_pc;
	acc_t  acc_x;
	acc_t  acc_y;
	acc_t  acc_z;
	acc_t  acc_r;
	logic  carry;
	logic  instr_ready;
	logic  done;
	logic  branch_taken;
	logic  unknown_opcode;
	pc_t   pc_next;
	int    mismatches = 0;
	int    checked = 0;
	int    cyc = 0;

	conditional_branch_unit u_dut (.core_clk, .rst_b, .instr_valid, .opcode, .operand_1,
		.operand_2, .instr_pc, .acc_x, .acc_y, .acc_z, .acc_r, .carry, .instr_ready, .done,
		.branch_taken, .unknown_opcode, .pc_next);
	fetch_model u_fetch (.core_clk, .instr_ready, .instr_valid, .opcode, .operand_1,
		.operand_2, .instr_pc);

	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// hang guard: about 145 cycles are needed
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			mismatches++;
			end_sim();
		end
	end

	// ---------------------------------------------------------------
	// shared checking
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
		checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// issue one instruction, count cycles to done, judge the result
	task automatic run(input byte_t op, input byte_t o1, input byte_t o2, input pc_t pc,
		input logic tk, input pc_t epc, input int n);
		int k;
		u_fetch.issue(op, o1, o2, pc);
		k = 1;
		while (done !== 1'b1 && k < 20)
		begin
			@(negedge core_clk);
			k++;
		end
		chk("cycles", 13'(n), 13'(k));
		chk("taken", {12'h000, tk}, {12'h000, branch_taken});
		chk("pc_next", epc, pc_next);
		chk("unknown", {12'h000, n == 2}, {12'h000, unknown_opcode});
	endtask
	// every accumulator, both kinds, bits 0, 23 and 31; target wraps at 8 kB
	task automatic t_bit_jumps();
		logic b;
		for (int s = 0; s < 4; s++)
			for (int k = 0; k < 2; k++)
				for (int i = 0; i < 3; i++)
				begin
					b = (i == 2) ? 1'b0 : acc_s(s, i == 0 ? 0 : 23);
					run({OP_BIT_ZERO_HI | 6'(k), 2'(s)}, i == 0 ? 8'h00 : (i == 1 ? 8'h17 : 8'h1f),
						s[0] ? 8'h05 : 8'hf0, 13'h1ffe, b == k[0],
						(b == k[0]) ? (s[0] ? 13'h0006 : 13'h1ff1) : 13'h0001, 4);
				end
	endtask
	// bit idx of the accumulator picked by s, as the bench set it up
	function automatic logic acc_s(input int s, input int idx);
		acc_s = s == 0 ? acc_x[idx] : (s == 1 ? acc_y[idx] : (s == 2 ? acc_z[idx] : acc_r[idx]));
	endfunction
	// both forms with carry clear and set
	task automatic t_carry();
		for (int c = 0; c < 2; c++)
		begin
			carry = c[0];
			run(OP_NO_CARRY_REL, 8'h80, 8'h5a, 13'h0010, !c[0],
				c[0] ? 13'h0012 : 13'h1f92, 3);
			run(OP_NO_CARRY_ABS, 8'hff, 8'hab, 13'h0010, !c[0],
				c[0] ? 13'h0013 : 13'h1fab, 4);
		end
	endtask

	task automatic end_sim();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		rst_b = 1'b0;
		carry = 1'b0;
		// bit 0 and bit 23 differ per accumulator so a wrong select shows
		acc_x = 24'h80_0000;
		acc_y = 24'h00_0001;
		acc_z = 24'hff_ffff;
		acc_r = 24'h7f_fffe;
		repeat (4) @(negedge core_clk);
		rst_b = 1'b1;
		t_bit_jumps();
		t_carry();
		run(8'h48, 8'h00, 8'h00, 13'h1fff, 1'b0, 13'h0000, 2);
		end_sim();
	end
endmodule // tb_conditional_branch_unit

bind conditional_branch_unit branch_unit_sva u_sva (.core_clk, .rst_b, .instr_valid, .opcode,
	.operand_1, .operand_2, .instr_pc, .acc_x, .acc_y, .acc_z, .acc_r, .carry, .instr_ready,
	.done, .branch_taken, .unknown_opcode, .pc_next);
